// ===== rtl/pwm_trig_gen.sv
// per-generator adc trigger, interrupt and output-mode logic with apb registers
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module pwm_trig_gen #(
	parameter int unsigned CW = 16
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic [CW-1:0]   local_primary_counter,
	input  wire logic [CW-1:0]   local_secondary_counter,
	input  wire logic [CW-1:0]   primary_master_counter,
	input  wire logic [CW-1:0]   secondary_master_counter,
	input  wire logic            primary_master_rollover,
	input  wire logic            secondary_master_rollover,
	input  wire logic            pwm_raw,
	input  wire logic            pwm_period_start,
	input  wire logic            current_limit_in,
	input  wire logic            fault_in,
	output logic                 primary_adc_trigger,
	output logic                 secondary_adc_trigger,
	output logic                 current_limit_adc_trigger,
	output logic                 special_event_trigger,
	output logic                 secondary_special_event_trigger,
	output logic                 generator_irq,
	output logic                 special_event_irq,
	output logic                 secondary_special_event_irq,
	output logic                 high_side_output,
	output logic                 low_side_output
);
	import pwm_trig_pkg::*;

	logic [31:0] trigger_control_reg_q;
	logic [31:0] generator_control_reg_q;
	logic [31:0] io_control_reg_q;
	logic [31:0] primary_timebase_control_q;
	logic [31:0] secondary_timebase_control_q;
	logic [CW-1:0] primary_trigger_compare_q;
	logic [CW-1:0] secondary_trigger_compare_q;
	logic [CW-1:0] primary_special_event_compare_q;
	logic [CW-1:0] secondary_special_event_compare_q;

	logic cl_s1_q, cl_s2_q, cl_s3_q;
	logic flt_s1_q, flt_s2_q, flt_s3_q;
	logic pwm_s1_q, pwm_s2_q;
	logic per_s1_q, per_s2_q;
	logic steer_q;
	logic trg_stat_q, cl_stat_q, flt_stat_q;
	logic prev_pri_match_q, prev_sec_match_q, prev_psev_q, prev_ssev_q;

	// compare decode used for four comparators
	function automatic logic coarse_eq(input logic [CW-1:0] a, input logic [CW-1:0] b);
		coarse_eq = (a[CW-1:CMP_IGNORE_LSB] == b[CW-1:CMP_IGNORE_LSB]);
	endfunction

	// level compares; edges taken so a coarse match lasting eight counts fires once
	wire pri_match_lvl  = coarse_eq(local_primary_counter, primary_trigger_compare_q);
	wire sec_match_lvl  = coarse_eq(local_secondary_counter, secondary_trigger_compare_q);
	wire psev_lvl       = coarse_eq(primary_master_counter, primary_special_event_compare_q);
	wire ssev_lvl       = coarse_eq(secondary_master_counter,
		secondary_special_event_compare_q);
	// counters reloaded by phase change simply jump; a skipped value is not caught up
	wire pri_match      = pri_match_lvl && !prev_pri_match_q;
	wire sec_match      = sec_match_lvl && !prev_sec_match_q;
	wire psev_match     = psev_lvl && !prev_psev_q;
	wire ssev_match     = ssev_lvl && !prev_ssev_q;
	wire master_rollover = primary_master_rollover || secondary_master_rollover;

	wire pri_fire;
	wire sec_fire;
	wire [3:0] trg_div = trigger_control_reg_q[TRG_DIV_LSB +: TRG_DIV_W];
	wire [5:0] trg_strt = trigger_control_reg_q[TRG_STRT_LSB +: TRG_STRT_W];
	wire dual_trigger_mode = trigger_control_reg_q[TRG_DTM_BIT];
	wire trigger_irq_enable = generator_control_reg_q[GEN_TRG_IEN];
	wire cl_irq_enable = generator_control_reg_q[GEN_CL_IEN];
	wire flt_irq_enable = generator_control_reg_q[GEN_FLT_IEN];

	trig_postscale u_pri (
		.pclk        (pclk),
		.presetn     (presetn),
		.match       (pri_match),
		.rollover    (master_rollover),
		.div         (trg_div),
		.start_delay (trg_strt),
		.fire        (pri_fire)
	);

	trig_postscale u_sec (
		.pclk        (pclk),
		.presetn     (presetn),
		.match       (sec_match),
		.rollover    (master_rollover),
		.div         (trg_div),
		.start_delay (trg_strt),
		.fire        (sec_fire)
	);

	// current-limit and fault events, rising edge of synchronised input
	wire cl_event  = cl_s2_q && !cl_s3_q;
	wire flt_event = flt_s2_q && !flt_s3_q;

	wire trg_stat_d = trigger_irq_enable && (trg_stat_q || pri_fire);
	wire cl_stat_d  = cl_stat_q || (cl_irq_enable && cl_event);
	wire flt_stat_d = flt_stat_q || (flt_irq_enable && flt_event);
	wire irq_d      = (trigger_irq_enable && pri_fire) || (cl_irq_enable && cl_event) ||
		(flt_irq_enable && flt_event);

	pin_mode_type pin_mode;
	assign pin_mode = pin_mode_type'(io_control_reg_q[IO_OUTPUT_PIN_MODE_LSB +: 2]);

	logic hi_d, lo_d;
	always_comb begin
		case (pin_mode)
		OUTPUT_PIN_MODE_COMPLEMENTARY: begin
			hi_d = pwm_s2_q;
			lo_d = !pwm_s2_q;
		end
		OUTPUT_PIN_MODE_PUSH_PULL: begin
			hi_d = pwm_s2_q && !steer_q;
			lo_d = pwm_s2_q && steer_q;
		end
		OUTPUT_PIN_MODE_REDUNDANT: begin
			hi_d = pwm_s2_q;
			lo_d = pwm_s2_q;
		end
		OUTPUT_PIN_MODE_INDEPENDENT: begin
			hi_d = pwm_s2_q;
			lo_d = 1'b0;
		end
		default: begin
			hi_d = 1'b0;
			lo_d = 1'b0;
		end
		endcase
	end

	// apb decode; zero-wait slave, errors on unmapped addresses
	wire access   = psel && penable;
	wire wr       = access && pwrite;
	wire mapped   = (paddr == ADDR_TRIG_CTRL) || (paddr == ADDR_GEN_CTRL) ||
		(paddr == ADDR_IO_CTRL) || (paddr == ADDR_PRI_CMP) || (paddr == ADDR_SEC_CMP) ||
		(paddr == ADDR_PTB_CTRL) || (paddr == ADDR_STB_CTRL) ||
		(paddr == ADDR_PSEV_CMP) || (paddr == ADDR_SSEV_CMP);
	wire [31:0] gen_rd = {16'h0000, flt_stat_q, cl_stat_q, trg_stat_q,
		generator_control_reg_q[12:0]};
	logic [31:0] rd_mux;
	always_comb begin
		case (paddr)
		ADDR_TRIG_CTRL: rd_mux = trigger_control_reg_q;
		ADDR_GEN_CTRL:  rd_mux = gen_rd;
		ADDR_IO_CTRL:   rd_mux = io_control_reg_q;
		ADDR_PRI_CMP:   rd_mux = {{(32-CW){1'b0}}, primary_trigger_compare_q};
		ADDR_SEC_CMP:   rd_mux = {{(32-CW){1'b0}}, secondary_trigger_compare_q};
		ADDR_PTB_CTRL:  rd_mux = primary_timebase_control_q;
		ADDR_STB_CTRL:  rd_mux = secondary_timebase_control_q;
		ADDR_PSEV_CMP:  rd_mux = {{(32-CW){1'b0}}, primary_special_event_compare_q};
		ADDR_SSEV_CMP:  rd_mux = {{(32-CW){1'b0}}, secondary_special_event_compare_q};
		default:        rd_mux = RDATA_UNMAPPED;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trigger_control_reg_q             <= REG_RESET;
			generator_control_reg_q           <= REG_RESET;
			io_control_reg_q                  <= REG_RESET;
			primary_timebase_control_q        <= REG_RESET;
			secondary_timebase_control_q      <= REG_RESET;
			primary_trigger_compare_q         <= '0;
			secondary_trigger_compare_q       <= '0;
			primary_special_event_compare_q   <= '0;
			secondary_special_event_compare_q <= '0;
		end else if (wr) begin
			case (paddr)
			ADDR_TRIG_CTRL: trigger_control_reg_q <= pwdata & 32'h0000_f0bf;
			ADDR_GEN_CTRL:  generator_control_reg_q <= {16'h0000, 3'b000, pwdata[12:0]};
			ADDR_IO_CTRL:   io_control_reg_q <= pwdata & 32'h0000_0c00;
			ADDR_PRI_CMP:   primary_trigger_compare_q <= pwdata[CW-1:0];
			ADDR_SEC_CMP:   secondary_trigger_compare_q <= pwdata[CW-1:0];
			ADDR_PTB_CTRL:  primary_timebase_control_q <= pwdata & 32'h0000_0800;
			ADDR_STB_CTRL:  secondary_timebase_control_q <= pwdata & 32'h0000_0800;
			ADDR_PSEV_CMP:  primary_special_event_compare_q <= pwdata[CW-1:0];
			ADDR_SSEV_CMP:  secondary_special_event_compare_q <= pwdata[CW-1:0];
			default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// answer registered: ready in the first cycle of the access phase
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{cl_s1_q, cl_s2_q, cl_s3_q}    <= 3'b000;
			{flt_s1_q, flt_s2_q, flt_s3_q} <= 3'b000;
			{pwm_s1_q, pwm_s2_q}           <= 2'b00;
			{per_s1_q, per_s2_q}           <= 2'b00;
		end else begin
			{cl_s1_q, cl_s2_q, cl_s3_q}    <= {current_limit_in, cl_s1_q, cl_s2_q};
			{flt_s1_q, flt_s2_q, flt_s3_q} <= {fault_in, flt_s1_q, flt_s2_q};
			{pwm_s1_q, pwm_s2_q}           <= {pwm_raw, pwm_s1_q};
			{per_s1_q, per_s2_q}           <= {pwm_period_start, per_s1_q};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_pri_match_q <= 1'b0;
			prev_sec_match_q <= 1'b0;
			prev_psev_q      <= 1'b0;
			prev_ssev_q      <= 1'b0;
			trg_stat_q       <= 1'b0;
			cl_stat_q        <= 1'b0;
			flt_stat_q       <= 1'b0;
			steer_q          <= 1'b0;
		end else begin
			prev_pri_match_q <= pri_match_lvl;
			prev_sec_match_q <= sec_match_lvl;
			prev_psev_q      <= psev_lvl;
			prev_ssev_q      <= ssev_lvl;
			trg_stat_q       <= trg_stat_d;
			cl_stat_q        <= cl_stat_d && cl_irq_enable;
			flt_stat_q       <= flt_stat_d && flt_irq_enable;
			if (per_s2_q)
				steer_q <= !steer_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			primary_adc_trigger             <= 1'b0;
			secondary_adc_trigger           <= 1'b0;
			current_limit_adc_trigger       <= 1'b0;
			special_event_trigger           <= 1'b0;
			secondary_special_event_trigger <= 1'b0;
			generator_irq                   <= 1'b0;
			special_event_irq               <= 1'b0;
			secondary_special_event_irq     <= 1'b0;
			high_side_output                <= 1'b0;
			low_side_output                 <= 1'b0;
		end else begin
			primary_adc_trigger <= pri_fire || (dual_trigger_mode && sec_fire);
			secondary_adc_trigger           <= sec_fire;
			current_limit_adc_trigger       <= cl_event;
			special_event_trigger           <= psev_match;
			secondary_special_event_trigger <= ssev_match;
			generator_irq                   <= irq_d;
			special_event_irq <= psev_match && primary_timebase_control_q[TB_SPECIAL_EVENT_IRQ_ENABLE_BIT];
			secondary_special_event_irq <= ssev_match &&
				secondary_timebase_control_q[TB_SPECIAL_EVENT_IRQ_ENABLE_BIT];
			high_side_output                <= hi_d;
			low_side_output                 <= lo_d;
		end
	end
endmodule

// ===== rtl/pwm_trig_pkg.sv
// constants and types for the pwm trigger, interrupt and output-mode block
//
// Behaviour
// - trigger when local primary/secondary counter equals its trigger compare value.
// - compares ignore the low three counter bits (8.32 ns vs 1.04 ns).
// - current-limit source and master special event can also trigger the adc.
// - primary matches postscaled, one trigger per N matches, N from 1 to 16.
// - first trigger waits a six-bit programmable number of pwm cycles.
// - start delay counts master timer rollovers, not local time base rollovers.
// - dual trigger mode ors primary and secondary pulses onto primary output.
// - trigger pulses always made; interrupt only when trigger irq enable set.
// - secondary compare matches never raise a pwm interrupt.
// - trigger status set by event, held until trigger irq enable cleared.
// - push-pull and center-aligned give two triggers of each kind per period; here one trigger per compare match in every mode.
// - phase change loads the local timer; skipped compares may be lost.
// - generator irq is or of trigger, current-limit and fault events.
// - any enabled source sets the generator flag at the interrupt controller.
// - status bits trigger 13, current-limit 14, fault 15 of control register.
// - primary and secondary special-event matches raise separate requests.
// - special-event interrupts gated by bit 11 of each time base control.
// - special-event and adc trigger pulses made regardless of interrupt enables.
// - two-bit pin mode field selects the output pairing mode.
// - push-pull routes successive pulses alternately to high and low pins.
// - complementary drives low side as inverse of high side.
// - pin mode 0 complementary, 1 redundant, 2 push-pull, 3 independent.
package pwm_trig_pkg;

	localparam int unsigned CNT_W = 16;

	localparam logic [7:0] ADDR_TRIG_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_GEN_CTRL   = 8'h04;
	localparam logic [7:0] ADDR_IO_CTRL    = 8'h08;
	localparam logic [7:0] ADDR_PRI_CMP    = 8'h0c;
	localparam logic [7:0] ADDR_SEC_CMP    = 8'h10;
	localparam logic [7:0] ADDR_PTB_CTRL   = 8'h14;
	localparam logic [7:0] ADDR_STB_CTRL   = 8'h18;
	localparam logic [7:0] ADDR_PSEV_CMP   = 8'h1c;
	localparam logic [7:0] ADDR_SSEV_CMP   = 8'h20;

	// trigger control fields
	localparam int unsigned TRG_DIV_LSB    = 12;
	localparam int unsigned TRG_DIV_W      = 4;
	localparam int unsigned TRG_DTM_BIT    = 7;
	localparam int unsigned TRG_STRT_LSB   = 0;
	localparam int unsigned TRG_STRT_W     = 6;
	// generator control fields
	localparam int unsigned GEN_FLT_STAT   = 15;
	localparam int unsigned GEN_CL_STAT    = 14;
	localparam int unsigned GEN_TRG_STAT   = 13;
	localparam int unsigned GEN_FLT_IEN    = 12;
	localparam int unsigned GEN_CL_IEN     = 11;
	localparam int unsigned GEN_TRG_IEN    = 10;
	localparam int unsigned GEN_CAM_BIT    = 2;
	localparam int unsigned GEN_ITB_BIT    = 9;
	// io control and time base control fields
	localparam int unsigned IO_OUTPUT_PIN_MODE_LSB    = 10;
	localparam int unsigned TB_SPECIAL_EVENT_IRQ_ENABLE_BIT   = 11;

	localparam int unsigned CMP_IGNORE_LSB = 3;
	localparam real         TRIG_RES_NS    = 8.32;
	localparam real         PWM_RES_NS     = 1.04;

	localparam logic [31:0] REG_RESET      = 32'h0000_0000;
	localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

	typedef enum logic [1:0] {
		OUTPUT_PIN_MODE_COMPLEMENTARY,
		OUTPUT_PIN_MODE_REDUNDANT,
		OUTPUT_PIN_MODE_PUSH_PULL,
		OUTPUT_PIN_MODE_INDEPENDENT
	} pin_mode_type;

endpackage

// ===== rtl/trig_postscale.sv
// postscaler and start delay for one compare trigger stream
`timescale 1ns/1ps
module trig_postscale (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       match,
	input  wire logic       rollover,
	input  wire logic [3:0] div,
	input  wire logic [5:0] start_delay,
	output logic            fire
);
	logic [3:0] ev_cnt_q;
	logic [5:0] wait_cnt_q;
	logic       armed;
	logic       hit;

	assign armed = (wait_cnt_q >= start_delay);
	assign hit   = armed && match && (ev_cnt_q == div);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_cnt_q   <= 4'h0;
			wait_cnt_q <= 6'h00;
			fire       <= 1'b0;
		end else begin
			// master rollovers only, so the wait follows the period grid
			if (rollover && !armed)
				wait_cnt_q <= wait_cnt_q + 6'h01;
			if (armed && match)
				ev_cnt_q <= hit ? 4'h0 : ev_cnt_q + 4'h1;
			fire <= hit;
		end
	end
endmodule

// ===== tb/pwm_trig_gen_monitor.sv
// port checker for the pwm trigger block
`timescale 1ns/1ps
module pwm_trig_gen_monitor (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       current_limit_in,
	input wire logic       primary_adc_trigger,
	input wire logic       secondary_adc_trigger,
	input wire logic       current_limit_adc_trigger,
	input wire logic       special_event_trigger,
	input wire logic       secondary_special_event_trigger,
	input wire logic       special_event_irq,
	input wire logic       secondary_special_event_irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_apb_ready: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_err_unmapped: assert property (psel && penable && pready |->
		pslverr == (paddr > 8'h20 || paddr[1:0] != 2'b00))
		else $error("error response wrong for address");
	a_pri_one_wide: assert property (primary_adc_trigger |=> !primary_adc_trigger)
		else $error("primary trigger wider than one cycle");
	a_sec_one_wide: assert property (secondary_adc_trigger |=> !secondary_adc_trigger)
		else $error("secondary trigger wider than one cycle");
	a_sev_one_wide: assert property (special_event_trigger |=> !special_event_trigger)
		else $error("special trigger wider than one cycle");
	a_cl_trig_follow: assert property ($rose(current_limit_in) |->
		##[1:5] current_limit_adc_trigger)
		else $error("no trigger after current limit");
	a_sev_irq_gate: assert property (special_event_irq |-> special_event_trigger)
		else $error("special irq without special trigger");
	a_ssev_irq_gate: assert property (secondary_special_event_irq |->
		secondary_special_event_trigger)
		else $error("secondary special irq without trigger");
endmodule
bind pwm_trig_gen pwm_trig_gen_monitor u_mon (.pclk, .presetn, .psel, .penable, .paddr, .pready,
	.pslverr, .current_limit_in, .primary_adc_trigger, .secondary_adc_trigger,
	.current_limit_adc_trigger, .special_event_trigger, .secondary_special_event_trigger,
	.special_event_irq, .secondary_special_event_irq);

// ===== tb/adc_irq_sink.sv
// adc and interrupt controller model: counts pulses, keeps the generator flag
`timescale 1ns/1ps
module adc_irq_sink (
	input wire logic         pclk,
	input wire logic         presetn,
	input wire logic [7:0]   ev,
	input wire logic         flag_clr,
	output logic [7:0][15:0] cnt,
	output logic             irq_flag
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
			irq_flag <= 1'b0;
		end else begin
			for (int i = 0; i < 8; i++)
				cnt[i] <= cnt[i] + 16'(ev[i]);
			irq_flag <= ev[5] | (irq_flag & !flag_clr);
		end
	end
endmodule

// ===== tb/pwm_trig_gen_bench.sv
// self-checking bench for the pwm trigger block
`timescale 1ns/1ps
module pwm_trig_gen_bench;
	import pwm_trig_pkg::*;
	logic             pclk, presetn, psel, penable, pwrite, run, roll, raw, pst, cl, flt, clr, h1;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, rnd, v;
	logic [15:0]      cv;
	logic [5:0]       cnt;
	wire  [31:0]      prdata;
	wire              pready, pslverr, hs, ls, flag;
	wire  [7:0]       ev;
	wire  [7:0][15:0] co;
	logic [32:0]      q[$];
	int               errors, total_checks, r, m, b, k;
	// div, start, dual, trig ien, sev ien, ssev ien, periods, primary, secondary, irq
	int t[7][10] = '{'{0,0,0,0,1,0,16,16,16,0}, '{1,0,0,0,0,1,16,8,-1,0},
		'{3,0,0,0,0,0,16,4,-1,0}, '{15,0,0,0,0,0,32,2,-1,0}, '{0,5,0,0,0,0,16,11,-1,0},
		'{2,63,0,0,0,0,66,1,-1,0}, '{0,0,1,1,1,1,16,32,16,16}};
	pwm_trig_gen #(.CW(CNT_W)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .local_primary_counter(cv),
		.local_secondary_counter(cv), .primary_master_counter(cv),
		.secondary_master_counter(cv), .primary_master_rollover(roll),
		.secondary_master_rollover(roll), .pwm_raw(raw), .pwm_period_start(pst),
		.current_limit_in(cl), .fault_in(flt), .primary_adc_trigger(ev[0]),
		.secondary_adc_trigger(ev[1]), .current_limit_adc_trigger(ev[2]),
		.special_event_trigger(ev[3]), .secondary_special_event_trigger(ev[4]),
		.generator_irq(ev[5]), .special_event_irq(ev[6]), .secondary_special_event_irq(ev[7]),
		.high_side_output(hs), .low_side_output(ls));
	adc_irq_sink u_sink (.pclk, .presetn, .ev, .flag_clr(clr), .cnt(co), .irq_flag(flag));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [32:0] s, input logic [32:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic stall;
		errors++;
		summarize();
	endtask
	// reads note their expected answer; the watcher below compares it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [32:0] e);
		int n;
		if (!w)
			q.push_back(e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(negedge pclk);
		while (pready !== 1'b1 && n < 16) begin
			@(negedge pclk);
			n++;
		end
		if (n == 16)
			stall();
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rst(input int n);
		presetn <= 1'b0;
		repeat (n) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	// counters frozen until run so the start delay is armed only by our rollovers
	task automatic go(input int p);
		int n;
		run <= 1'b1;
		for (int i = 0; i < p; i++) begin
			n = 0;
			do begin
				@(negedge pclk);
				n++;
			end while (roll !== 1'b1 && n < 100);
			if (n == 100)
				stall();
		end
		@(posedge pclk);
		run <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	always #50 pclk = ~pclk;
	// low bits random: a match must ignore them
	always @(posedge pclk) begin
		rnd <= lfsr(rnd);
		roll <= run && cnt == 6'h3f;
		// idle coarse value matches no compare, so a cleared compare gives no pulse at reset
		cv <= {6'h00, !run, cnt, rnd[2:0]};
		cnt <= run ? cnt + 6'h01 : 6'h00;
	end
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite)
			check({pslverr, prdata}, q.pop_front());
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, run, roll, raw, pst, cl, flt, clr} = '0;
		{paddr, pwdata, cv, cnt} = '0;
		rnd = 32'h8c97afe3;
		rst(20);
		for (k = 0; k < 9; k++)
			apb(1'b0, 8'(k * 4), 32'h0, {1'b0, REG_RESET});
		apb(1'b1, 8'h40, 32'hffff_ffff, 33'h0);
		apb(1'b0, 8'h40, 32'h0, {1'b1, RDATA_UNMAPPED});
		for (k = 0; k < 4; k++) begin
			v = rnd;
			apb(1'b1, ADDR_PRI_CMP, v, 33'h0);
			apb(1'b0, ADDR_PRI_CMP, 32'h0, {17'h0, v[15:0]});
		end
		for (r = 0; r < 7; r++) begin
			rst(2);
			apb(1'b1, ADDR_PRI_CMP, 32'h0103, 33'h0);
			apb(1'b1, ADDR_SEC_CMP, 32'h0045, 33'h0);
			apb(1'b1, ADDR_PSEV_CMP, 32'h0087, 33'h0);
			apb(1'b1, ADDR_SSEV_CMP, 32'h00c1, 33'h0);
			apb(1'b1, ADDR_TRIG_CTRL, 32'(t[r][0] * 4096 + t[r][2] * 128 + t[r][1]), 33'h0);
			apb(1'b1, ADDR_GEN_CTRL, 32'(t[r][3] * 1024), 33'h0);
			apb(1'b1, ADDR_PTB_CTRL, 32'(t[r][4] * 2048), 33'h0);
			apb(1'b1, ADDR_STB_CTRL, 32'(t[r][5] * 2048), 33'h0);
			go(t[r][6]);
			check(co[0], t[r][7]);
			if (t[r][8] >= 0)
				check(co[1], t[r][8]);
			check(co[5], t[r][9]);
			check(co[3], t[r][6]);
			check(co[4], t[r][6]);
			check(co[6], t[r][6] * t[r][4]);
			check(co[7], t[r][6] * t[r][5]);
			apb(1'b0, ADDR_GEN_CTRL, 32'h0, 33'(t[r][3] * 32'h2400));
		end
		rst(2);
		apb(1'b1, ADDR_GEN_CTRL, 32'h1800, 33'h0);
		cl <= 1'b1;
		repeat (8) @(posedge pclk);
		flt <= 1'b1;
		repeat (8) @(posedge pclk);
		check(co[5], 2);
		check(co[2], 1);
		check(flag, 1);
		apb(1'b0, ADDR_GEN_CTRL, 32'h0, 33'hd800);
		apb(1'b1, ADDR_GEN_CTRL, 32'h0, 33'h0);
		apb(1'b0, ADDR_GEN_CTRL, 32'h0, 33'h0);
		clr <= 1'b1;
		{cl, flt} <= 2'b00;
		@(posedge pclk);
		clr <= 1'b0;
		@(negedge pclk);
		check(flag, 0);
		for (m = 0; m < 4; m++)
			for (b = 0; b < 2; b++)
				if (m != 2) begin
					apb(1'b1, ADDR_IO_CTRL, 32'(m * 1024), 33'h0);
					raw <= b[0];
					repeat (6) @(posedge pclk);
					@(negedge pclk);
					check({hs, ls}, {b[0], m == 0 ? !b[0] : m == 1 && b[0]});
				end
		apb(1'b1, ADDR_IO_CTRL, 32'(OUTPUT_PIN_MODE_PUSH_PULL) << IO_OUTPUT_PIN_MODE_LSB, 33'h0);
		raw <= 1'b1;
		for (k = 0; k < 2; k++) begin
			@(posedge pclk);
			pst <= 1'b1;
			@(posedge pclk);
			pst <= 1'b0;
			repeat (6) @(posedge pclk);
			@(negedge pclk);
			check(hs ^ ls, 1);
			if (k == 1)
				check(hs, !h1);
			h1 = hs;
		end
		summarize();
	end
endmodule
